//--- inc/timer16_pkg.sv
package timer16_pkg;
  localparam logic [7:0]  TIMER_CONTROL_A_ADDR = 8'h80;
  localparam logic [7:0]  TIMER_CONTROL_B_ADDR = 8'h81;
  localparam logic [7:0]  COMPARE_A_LO_ADDR    = 8'h88;
  localparam logic [7:0]  COMPARE_A_HI_ADDR    = 8'h89;
  localparam logic [7:0]  COMPARE_B_LO_ADDR    = 8'h8A;
  localparam logic [7:0]  COMPARE_B_HI_ADDR    = 8'h8B;
  localparam logic [7:0]  CAPTURE_LO_ADDR      = 8'h86;
  localparam logic [7:0]  CAPTURE_HI_ADDR      = 8'h87;
  localparam logic [7:0]  COUNT_LO_ADDR        = 8'h84;
  localparam logic [7:0]  COUNT_HI_ADDR        = 8'h85;
  localparam logic [7:0]  STATUS_ADDR          = 8'h8C;
  localparam logic [7:0]  CTRL_RESET           = 8'h00;
  localparam logic [7:0]  CTRL_A_MASK          = 8'hF3;
  localparam logic [7:0]  CTRL_B_MASK          = 8'hDF;
  localparam int          CHAN_A_MODE_HI       = 7;
  localparam int          CHAN_B_MODE_HI       = 5;
  localparam int          FILTER_EN_BIT        = 7;
  localparam int          EDGE_SEL_BIT         = 6;
  localparam logic [15:0] MAX_VALUE            = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT             = 16'h00FF;
  localparam logic [15:0] TOP_9BIT             = 16'h01FF;
  localparam logic [15:0] TOP_10BIT            = 16'h03FF;
  localparam logic [15:0] BOTTOM_VALUE         = 16'h0000;
  localparam int          FILTER_SAMPLES       = 4;
  localparam logic [9:0]  DIV_8_MASK           = 10'h007;
  localparam logic [9:0]  DIV_64_MASK          = 10'h03F;
  localparam logic [9:0]  DIV_256_MASK         = 10'h0FF;
  localparam logic [9:0]  DIV_1024_MASK        = 10'h3FF;

  typedef enum logic [2:0] {
    CS_STOP   = 3'b000,
    CS_DIV1   = 3'b001,
    CS_DIV8   = 3'b010,
    CS_DIV64  = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1K  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clock_select_e;

  typedef enum logic [1:0] {
    SEQ_NORMAL = 2'b00,
    SEQ_CTC    = 2'b01,
    SEQ_FAST   = 2'b10,
    SEQ_DUAL   = 2'b11
  } seq_kind_e;

  typedef enum logic [1:0] {
    TOPSRC_FIXED   = 2'b00,
    TOPSRC_COMPARE = 2'b01,
    TOPSRC_CAPTURE = 2'b10
  } top_src_e;

  typedef enum logic [1:0] {
    UPD_IMMEDIATE = 2'b00,
    UPD_TOP       = 2'b01,
    UPD_BOTTOM    = 2'b10
  } update_pt_e;
endpackage : timer16_pkg

//--- hw/timer16_waveform_control.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - synchronous except the asynchronous reset; timer tick is a one-cycle count enable only
// - phase-and-frequency-correct modes load compare buffers at BOTTOM
// - nonzero channel output field routes waveform onto pin
// - pin driven only when the port direction bit is set
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM 01 toggles A only in modes 14/15, B off
// - fast PWM 10 clear on match set at BOTTOM; 11 inverse
// - fast PWM 10/11 with compare equal TOP ignores match, BOTTOM action kept
// - dual-slope 01 toggles A only in modes 9/11, B off
// - dual-slope 10 clear up-match, set down-match; 11 inverse
// - mode = control B bits 4:3 over control A bits 1:0
// - modes 0,4,12: free/CTC, immediate update, flag at MAX
// - modes 1-3 phase-correct with TOP FF/1FF/3FF, update TOP
// - modes 5-7 fast PWM fixed TOP, update BOTTOM, flag TOP
// - modes 8,9 phase-freq-correct, TOP capture/compare A, BOTTOM
// - 10,11 phase-correct; 14,15 fast PWM; 13 reserved
// - control B bit 7 enables capture input noise filter
// - filter needs four equal samples, delaying capture five cycles
// - clock select: stop, div 1/8/64/256/1024, external fall/rise
// - capture pin disconnected when capture register is TOP
module timer16_waveform_control
  import timer16_pkg::*;
#(
  parameter int PRESCALE_W = 10
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ext_clock_pin_i,
  input  wire logic       capture_pin_i,
  input  wire logic       chan_a_dir_i,
  input  wire logic       chan_b_dir_i,
  output logic            chan_a_wave_out_o,
  output logic            chan_a_wave_oe_o,
  output logic            chan_b_wave_out_o,
  output logic            chan_b_wave_oe_o,
  output logic            overflow_flag_o,
  output logic            compare_match_a_o,
  output logic            compare_match_b_o,
  output logic            capture_event_o
);

  typedef struct packed {
    logic [7:0]            ctrl_a;
    logic [7:0]            ctrl_b;
    logic [15:0]           count;
    logic                  down;
    logic [15:0]           cmp_buf_a;
    logic [15:0]           cmp_buf_b;
    logic [15:0]           cmp_a;
    logic [15:0]           cmp_b;
    logic [15:0]           capture;
    logic [7:0]            temp;
    logic [PRESCALE_W-1:0] prescale;
    logic                  ext_prev;
    logic [FILTER_SAMPLES-1:0] filt_hist;
    logic                  filt_out;
    logic                  cap_prev;
    logic [1:0]            wave;
    logic [3:0]            events;
    logic [7:0]            rdata;
  } state_s;

  state_s st_r, st_nxt;

  logic [3:0]    wave_mode;
  seq_kind_e     seq;
  top_src_e      top_src;
  update_pt_e    upd_pt;
  logic [15:0]   top_val;
  logic          tick;
  logic          at_top, at_bottom, at_max;
  logic [15:0]   cmp_v [2];
  logic [1:0]    chan_mode [2];
  logic [1:0]    match;
  logic [1:0]    wave_nxt;
  logic [1:0]    route_en;
  logic          cap_src, cap_edge, ovf_evt;

  assign wave_mode = {st_r.ctrl_b[4:3], st_r.ctrl_a[1:0]};
  assign cmp_v[0]  = st_r.cmp_a;
  assign cmp_v[1]  = st_r.cmp_b;
  assign chan_mode[0] = st_r.ctrl_a[CHAN_A_MODE_HI -: 2];
  assign chan_mode[1] = st_r.ctrl_a[CHAN_B_MODE_HI -: 2];

  // mode table
  always_comb begin
    seq     = SEQ_NORMAL;
    top_src = TOPSRC_FIXED;
    upd_pt  = UPD_IMMEDIATE;
    top_val = MAX_VALUE;
    case (wave_mode)
      4'h0: begin
        seq = SEQ_NORMAL;
      end
      4'h1, 4'h2, 4'h3: begin
        seq    = SEQ_DUAL;
        upd_pt = UPD_TOP;
      end
      4'h4: begin
        seq     = SEQ_CTC;
        top_src = TOPSRC_COMPARE;
      end
      4'h5, 4'h6, 4'h7: begin
        seq    = SEQ_FAST;
        upd_pt = UPD_BOTTOM;
      end
      4'h8, 4'h9: begin
        seq     = SEQ_DUAL;
        upd_pt  = UPD_BOTTOM;
        top_src = wave_mode[0] ? TOPSRC_COMPARE : TOPSRC_CAPTURE;
      end
      4'hA, 4'hB: begin
        seq     = SEQ_DUAL;
        upd_pt  = UPD_TOP;
        top_src = wave_mode[0] ? TOPSRC_COMPARE : TOPSRC_CAPTURE;
      end
      4'hC: begin
        seq     = SEQ_CTC;
        top_src = TOPSRC_CAPTURE;
      end
      4'hD: begin
        seq = SEQ_NORMAL;
      end
      4'hE, 4'hF: begin
        seq     = SEQ_FAST;
        upd_pt  = UPD_BOTTOM;
        top_src = wave_mode[0] ? TOPSRC_COMPARE : TOPSRC_CAPTURE;
      end
      default: seq = SEQ_NORMAL;
    endcase
    case (top_src)
      TOPSRC_COMPARE: top_val = st_r.cmp_a;
      TOPSRC_CAPTURE: top_val = st_r.capture;
      default: begin
        case (wave_mode[1:0])
          2'b01:   top_val = TOP_8BIT;
          2'b10:   top_val = TOP_9BIT;
          2'b11:   top_val = TOP_10BIT;
          default: top_val = MAX_VALUE;
        endcase
      end
    endcase
  end

  // count enable from prescaler or external pin edge
  always_comb begin
    case (clock_select_e'(st_r.ctrl_b[2:0]))
      CS_STOP:   tick = 1'b0;
      CS_DIV1:   tick = 1'b1;
      CS_DIV8:   tick = (st_r.prescale[9:0] & DIV_8_MASK) == DIV_8_MASK;
      CS_DIV64:  tick = (st_r.prescale[9:0] & DIV_64_MASK) == DIV_64_MASK;
      CS_DIV256: tick = (st_r.prescale[9:0] & DIV_256_MASK) == DIV_256_MASK;
      CS_DIV1K:  tick = st_r.prescale[9:0] == DIV_1024_MASK;
      CS_EXT_FALL: tick = st_r.ext_prev & ~ext_clock_pin_i;
      CS_EXT_RISE: tick = ~st_r.ext_prev & ext_clock_pin_i;
      default:   tick = 1'b0;
    endcase
  end

  assign at_top    = st_r.count == top_val;
  assign at_bottom = st_r.count == BOTTOM_VALUE;
  assign at_max    = st_r.count == MAX_VALUE;

  // per-channel compare output decode
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      always_comb begin
        logic cm;
        logic w;
        cm = 1'b0;
        w  = st_r.wave[gi];
        cm = tick && st_r.count == cmp_v[gi];
        case (seq)
          SEQ_FAST: begin
            if (chan_mode[gi][1] && cmp_v[gi] == top_val)
              cm = 1'b0;
            if (chan_mode[gi] == 2'b01) begin
              if (gi == 0 && wave_mode[3:1] == 3'b111 && cm)
                w = ~w;
            end else if (chan_mode[gi][1]) begin
              if (tick && at_top)
                w = ~chan_mode[gi][0];
              else if (cm)
                w = chan_mode[gi][0];
            end
          end
          SEQ_DUAL: begin
            if (chan_mode[gi] == 2'b01) begin
              if (gi == 0 && wave_mode[3] && wave_mode[0] && cm)
                w = ~w;
            end else if (chan_mode[gi][1] && cm) begin
              w = chan_mode[gi][0] ^ st_r.down;
            end
          end
          default: begin
            if (cm) begin
              case (chan_mode[gi])
                2'b01:   w = ~w;
                2'b10:   w = 1'b0;
                2'b11:   w = 1'b1;
                default: w = st_r.wave[gi];
              endcase
            end
          end
        endcase
        match[gi]    = cm;
        wave_nxt[gi] = w;
      end
      assign route_en[gi] = chan_mode[gi] != 2'b00;
    end
  endgenerate

  // capture filter and edge
  always_comb begin
    cap_src = st_r.ctrl_b[FILTER_EN_BIT] ? st_r.filt_out
                                         : capture_pin_i;
    cap_edge = (cap_src != st_r.cap_prev) &&
               (cap_src == st_r.ctrl_b[EDGE_SEL_BIT]) &&
               top_src != TOPSRC_CAPTURE;
  end

  always_comb begin
    st_nxt = st_r;
    ovf_evt = 1'b0;
    st_nxt.prescale = st_r.prescale + 1'b1;
    st_nxt.ext_prev = ext_clock_pin_i;
    st_nxt.filt_hist = {st_r.filt_hist[FILTER_SAMPLES-2:0], capture_pin_i};
    if (&st_r.filt_hist || ~|st_r.filt_hist)
      st_nxt.filt_out = st_r.filt_hist[0];
    st_nxt.cap_prev = cap_src;
    if (cap_edge)
      st_nxt.capture = st_r.count;
    st_nxt.wave = wave_nxt;
    if (tick) begin
      case (seq)
        SEQ_DUAL: begin
          if (at_top) begin
            st_nxt.down  = 1'b1;
            st_nxt.count = st_r.count - 1'b1;
          end else if (at_bottom) begin
            st_nxt.down  = 1'b0;
            st_nxt.count = st_r.count + 1'b1;
            ovf_evt      = 1'b1;
          end else begin
            st_nxt.count = st_r.down ? st_r.count - 1'b1 : st_r.count + 1'b1;
          end
        end
        SEQ_FAST, SEQ_CTC: begin
          st_nxt.down  = 1'b0;
          st_nxt.count = at_top ? BOTTOM_VALUE : st_r.count + 1'b1;
          ovf_evt      = seq == SEQ_FAST ? at_top : at_max;
        end
        default: begin
          st_nxt.down  = 1'b0;
          st_nxt.count = st_r.count + 1'b1;
          ovf_evt      = at_max;
        end
      endcase
      if ((upd_pt == UPD_TOP && at_top) ||
          (upd_pt == UPD_BOTTOM && (seq == SEQ_FAST ? at_top : at_bottom)))
      begin
        st_nxt.cmp_a = st_r.cmp_buf_a;
        st_nxt.cmp_b = st_r.cmp_buf_b;
      end
    end
    if (upd_pt == UPD_IMMEDIATE) begin
      st_nxt.cmp_a = st_r.cmp_buf_a;
      st_nxt.cmp_b = st_r.cmp_buf_b;
    end
    st_nxt.events = {cap_edge, match[1], match[0], ovf_evt};
    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        TIMER_CONTROL_A_ADDR: st_nxt.rdata = st_r.ctrl_a;
        TIMER_CONTROL_B_ADDR: st_nxt.rdata = st_r.ctrl_b;
        COUNT_LO_ADDR: begin
          st_nxt.rdata = st_r.count[7:0];
          st_nxt.temp  = st_r.count[15:8];
        end
        CAPTURE_LO_ADDR: begin
          st_nxt.rdata = st_r.capture[7:0];
          st_nxt.temp  = st_r.capture[15:8];
        end
        COUNT_HI_ADDR, CAPTURE_HI_ADDR: st_nxt.rdata = st_r.temp;
        COMPARE_A_LO_ADDR: st_nxt.rdata = st_r.cmp_buf_a[7:0];
        COMPARE_A_HI_ADDR: st_nxt.rdata = st_r.cmp_buf_a[15:8];
        COMPARE_B_LO_ADDR: st_nxt.rdata = st_r.cmp_buf_b[7:0];
        COMPARE_B_HI_ADDR: st_nxt.rdata = st_r.cmp_buf_b[15:8];
        STATUS_ADDR: st_nxt.rdata = {3'h0, st_r.down, st_r.events};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        TIMER_CONTROL_A_ADDR: st_nxt.ctrl_a = wdata_i & CTRL_A_MASK;
        TIMER_CONTROL_B_ADDR: st_nxt.ctrl_b = wdata_i & CTRL_B_MASK;
        COUNT_HI_ADDR, CAPTURE_HI_ADDR, COMPARE_A_HI_ADDR,
        COMPARE_B_HI_ADDR: st_nxt.temp = wdata_i;
        COUNT_LO_ADDR:     st_nxt.count = {st_r.temp, wdata_i};
        CAPTURE_LO_ADDR:   st_nxt.capture = {st_r.temp, wdata_i};
        COMPARE_A_LO_ADDR: st_nxt.cmp_buf_a = {st_r.temp, wdata_i};
        COMPARE_B_LO_ADDR: st_nxt.cmp_buf_b = {st_r.temp, wdata_i};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o           = st_r.rdata;
  assign chan_a_wave_out_o = st_r.wave[0];
  assign chan_b_wave_out_o = st_r.wave[1];
  assign chan_a_wave_oe_o  = route_en[0] & chan_a_dir_i;
  assign chan_b_wave_oe_o  = route_en[1] & chan_b_dir_i;
  assign overflow_flag_o   = st_r.events[0];
  assign compare_match_a_o = st_r.events[1];
  assign compare_match_b_o = st_r.events[2];
  assign capture_event_o   = st_r.events[3];

  a_filter_delay: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (st_r.ctrl_b[FILTER_EN_BIT] && $stable(st_r.ctrl_b) &&
     (&st_r.filt_hist) && !st_r.filt_out) |=> st_r.filt_out)
    else $error("filter output did not follow four equal samples");

  a_oe_needs_dir: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !chan_a_dir_i |-> !chan_a_wave_oe_o)
    else $error("channel a driven without direction bit");

  a_route_on_mode: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (chan_mode[1] != 2'b00 && chan_b_dir_i) |-> chan_b_wave_oe_o)
    else $error("channel b not routed");

  a_stop_holds: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (st_r.ctrl_b[2:0] == 3'b000 && !wr_i) |=> $stable(st_r.count))
    else $error("counter moved while stopped");

  a_capture_off: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (top_src == TOPSRC_CAPTURE) |=> !capture_event_o)
    else $error("capture while capture register is top");

  a_nonpwm_clear: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (seq == SEQ_NORMAL && chan_mode[0] == 2'b10 && match[0])
      |=> !chan_a_wave_out_o)
    else $error("clear on match failed");

  a_dual_down: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (seq == SEQ_DUAL && chan_mode[0] == 2'b10 && match[0] && st_r.down)
      |=> chan_a_wave_out_o)
    else $error("down-count match did not set output");

  a_fast_bottom: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (seq == SEQ_FAST && chan_mode[1] == 2'b11 && tick && at_top)
      |=> !chan_b_wave_out_o)
    else $error("inverting fast pwm not cleared at bottom");

endmodule : timer16_waveform_control
`default_nettype wire

//--- bench/timer16_waveform_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module timer16_waveform_control_bench;
  import timer16_pkg::*;
  logic       clock_i, rst_i, wr_i, rd_i, ext_clock_pin_i, capture_pin_i;
  logic       chan_a_dir_i, chan_b_dir_i, ext_run, s1, s2;
  logic       wave_a, oe_a, wave_b, oe_b, ovf, cmp_a, cmp_b, cap_ev;
  logic [7:0] addr_i, wdata_i, rdata_o, d, v;
  logic [3:0] evs, md;
  logic [15:0] w16;
  logic [3:0] tmodes [5] = '{4'h5, 4'hF, 4'h1, 4'h9, 4'hB};
  logic [3:0] pmodes [5] = '{4'h6, 4'h7, 4'h2, 4'h3, 4'hE};
  int         pers [5] = '{512, 1024, 1022, 2046, 49};
  int         divs [8] = '{0, 1, 8, 64, 256, 1024, 6, 6};
  int         error_cnt, num_checks, cyc, n, m, la, lb;

  assign evs = {cap_ev, cmp_b, cmp_a, ovf};

  timer16_waveform_control dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_clock_pin_i(ext_clock_pin_i), .capture_pin_i(capture_pin_i),
    .chan_a_dir_i(chan_a_dir_i), .chan_b_dir_i(chan_b_dir_i),
    .chan_a_wave_out_o(wave_a), .chan_a_wave_oe_o(oe_a),
    .chan_b_wave_out_o(wave_b), .chan_b_wave_oe_o(oe_b),
    .overflow_flag_o(ovf), .compare_match_a_o(cmp_a),
    .compare_match_b_o(cmp_b), .capture_event_o(cap_ev));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // external count pin: one edge of each kind every six cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (ext_run && cyc % 3 == 0) ext_clock_pin_i <= !ext_clock_pin_i;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (e !== g) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_bit(string nm, logic e, logic g);
    num_checks++;
    if (e !== g) begin
      error_cnt++;
      $display("wrong value %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic wr(logic [7:0] a, logic [7:0] x);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= x;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, output logic [7:0] x);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    x = rdata_o;
  endtask : rd

  // high byte first, low byte commits
  task automatic wr16(logic [7:0] hi, logic [15:0] x);
    wr(hi, x[15:8]);
    wr(hi - 8'h01, x[7:0]);
  endtask : wr16

  task automatic setm(logic [3:0] mo, logic [1:0] ca, logic [1:0] cb,
                      logic [2:0] cs, logic [1:0] fe);
    wr(TIMER_CONTROL_A_ADDR, {ca, cb, 2'b00, mo[1:0]});
    wr(TIMER_CONTROL_B_ADDR, {fe, 1'b0, mo[3:2], cs});
  endtask : setm

  // stop in an immediate-update mode so compare values land at once
  task automatic prep(logic [15:0] ca, logic [15:0] cb);
    setm(4'h0, 2'b00, 2'b00, 3'b000, 2'b00);
    wr16(COMPARE_A_HI_ADDR, ca);
    wr16(COMPARE_B_HI_ADDR, cb);
    wr16(COUNT_HI_ADDR, 16'h0000);
  endtask : prep

  task automatic idle(int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : idle

  // c is cycles to the pulse, lim + 1 if none came
  task automatic wait_ev(int k, int lim, output int c);
    c = 0;
    do begin
      @(posedge clock_i);
      #1;
      c++;
    end while (evs[k] !== 1'b1 && c < lim);
    if (evs[k] !== 1'b1) c = lim + 1;
  endtask : wait_ev

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {wr_i, rd_i, ext_clock_pin_i, capture_pin_i, ext_run} = '0;
    {chan_a_dir_i, chan_b_dir_i, addr_i, wdata_i} = '0;
    {error_cnt, num_checks, cyc} = '0;
    rst_i = 1'b1;
    n = $urandom(32'hE830);
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(TIMER_CONTROL_A_ADDR, d);
    chk_val("ctrl_a", 16'h0000, {8'h00, d});
    rd(TIMER_CONTROL_B_ADDR, d);
    chk_val("ctrl_b", 16'h0000, {8'h00, d});
    rd(8'h82, d);
    chk_val("unmapped", 16'h0000, {8'h00, d});
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      wr(TIMER_CONTROL_A_ADDR, v);
      wr(TIMER_CONTROL_B_ADDR, v);
      rd(TIMER_CONTROL_A_ADDR, d);
      chk_val("ctrl_a", {8'h00, v & CTRL_A_MASK}, {8'h00, d});
      rd(TIMER_CONTROL_B_ADDR, d);
      chk_val("ctrl_b", {8'h00, v & CTRL_B_MASK}, {8'h00, d});
    end
    // 16-bit pairs: count, capture, compare a, compare b while stopped
    setm(4'h0, 2'b00, 2'b00, 3'b000, 2'b00);
    for (int i = 0; i < 4; i++) begin
      w16 = 16'($urandom());
      wr16(8'(COUNT_HI_ADDR + 2 * i), w16);
      rd(8'(COUNT_LO_ADDR + 2 * i), d);
      rd(8'(COUNT_HI_ADDR + 2 * i), v);
      chk_val("reg16", w16, {v, d});
    end
    $display("test registers done");
    for (int f = 0; f < 8; f++) begin
      chan_a_dir_i <= f[2];
      chan_b_dir_i <= !f[2];
      setm(4'h0, f[1:0], f[1:0], 3'b000, 2'b00);
      #1;
      chk_bit("oe_a", f[1:0] != 2'b00 && f[2], oe_a);
      chk_bit("oe_b", f[1:0] != 2'b00 && !f[2], oe_b);
    end
    $display("test pin enable done");
    for (int c = 2; c < 4; c++) begin
      prep(16'd9, 16'd4);
      setm(4'h4, 2'b01, c[1:0], 3'b001, 2'b00);
      wait_ev(1, 20, n);
      idle(2);
      s1 = wave_a;
      chk_bit("ctc_b", c == 3, wave_b);
      wait_ev(1, 20, n);
      idle(2);
      chk_bit("ctc_a", !s1, wave_a);
      wait_ev(2, 20, n);
      wait_ev(2, 20, n);
      chk_val("ctc_b_per", 16'd10, n[15:0]);
    end
    prep(16'd4, 16'd0);
    wr16(CAPTURE_HI_ADDR, 16'd9);
    setm(4'hC, 2'b00, 2'b00, 3'b001, 2'b01);
    capture_pin_i <= 1'b1;
    wait_ev(3, 20, n);
    chk_bit("cap_off", 1'b0, n <= 20);
    capture_pin_i <= 1'b0;
    wait_ev(1, 30, n);
    wait_ev(1, 30, n);
    chk_val("cap_top_per", 16'd10, n[15:0]);
    prep(16'd0, 16'd0);
    wr16(COUNT_HI_ADDR, 16'hFFF0);
    setm(4'h0, 2'b00, 2'b00, 3'b001, 2'b00);
    wait_ev(0, 40, n);
    chk_bit("ovf_max", 1'b1, n >= 16 && n <= 20);
    $display("test non-pwm done");
    prep(16'd3, 16'd0);
    for (int s = 1; s < 8; s++) begin
      ext_run = s > 5;
      setm(4'h4, 2'b00, 2'b00, s[2:0], 2'b00);
      wait_ev(1, 4 * divs[s] + 20, n);
      wait_ev(1, 4 * divs[s] + 20, n);
      chk_val("tick_per", 16'(4 * divs[s]), n[15:0]);
    end
    ext_run = 1'b0;
    setm(4'h4, 2'b00, 2'b00, 3'b000, 2'b00);
    wait_ev(1, 60, n);
    chk_bit("stopped", 1'b0, n <= 60);
    $display("test clock select done");
    for (int c = 2; c < 4; c++) begin
      prep(16'h0040, 16'h00FF);
      setm(4'h5, c[1:0], c[1:0], 3'b001, 2'b00);
      wait_ev(0, 300, n);
      wait_ev(0, 300, n);
      chk_val("fpwm_per", 16'd256, n[15:0]);
      idle(5);
      chk_bit("fpwm_a_bot", c == 2, wave_a);
      chk_bit("fpwm_b_bot", c == 2, wave_b);
      idle(123);
      chk_bit("fpwm_a_mid", c == 3, wave_a);
      chk_bit("fpwm_b_mid", c == 2, wave_b);
      prep(16'h0040, 16'h0040);
      setm(4'h1, c[1:0], c[1:0], 3'b001, 2'b00);
      wait_ev(0, 600, n);
      wait_ev(0, 600, n);
      chk_val("pc_per", 16'd510, n[15:0]);
      idle(5);
      chk_bit("pc_a_bot", c == 2, wave_a);
      idle(245);
      chk_bit("pc_a_top", c == 3, wave_a);
      chk_bit("pc_b_top", c == 3, wave_b);
    end
    for (int k = 0; k < 2; k++) begin
      prep(16'h0010, 16'h0010);
      wr16(CAPTURE_HI_ADDR, 16'h0030);
      setm(k ? 4'hA : 4'h8, 2'b10, 2'b10, 3'b001, 2'b00);
      wait_ev(0, 200, n);
      wait_ev(0, 200, n);
      chk_val("cap_top_dual", 16'd96, n[15:0]);
    end
    for (int k = 0; k < 5; k++) begin
      prep(16'h0010, 16'h0010);
      wr16(CAPTURE_HI_ADDR, 16'h0030);
      setm(pmodes[k], 2'b00, 2'b00, 3'b001, 2'b00);
      wait_ev(0, 2100, n);
      wait_ev(0, 2100, n);
      chk_val("mode_per", 16'(pers[k]), n[15:0]);
    end
    for (int k = 0; k < 5; k++) begin
      md = tmodes[k];
      prep(16'h0020, 16'h0010);
      setm(md, 2'b01, 2'b01, 3'b001, 2'b00);
      wait_ev(0, 600, n);
      idle(3);
      s1 = wave_a;
      s2 = wave_b;
      wait_ev(0, 600, n);
      idle(3);
      chk_bit("tog_a", md inside {4'h9, 4'hB, 4'hF},
              wave_a != s1);
      chk_bit("tog_b", 1'b0, wave_b != s2);
    end
    $display("test pwm done");
    prep(16'd0, 16'd0);
    for (int f = 0; f < 2; f++) begin
      setm(4'h0, 2'b00, 2'b00, 3'b001, {f[0], 1'b1});
      idle(8);
      capture_pin_i <= 1'b1;
      wait_ev(3, 3, n);
      capture_pin_i <= 1'b0;
      wait_ev(3, 12, m);
      chk_bit("glitch", f == 0, n <= 3 || m <= 12);
      idle(8);
      capture_pin_i <= 1'b1;
      wait_ev(3, 20, n);
      if (f == 0) la = n;
      else lb = n;
      capture_pin_i <= 1'b0;
      idle(10);
    end
    chk_bit("filt_on", 1'b1, lb <= 20);
    chk_bit("filt_delay", 1'b1, lb - la >= 4 && lb - la <= 5);
    $display("test capture filter done");
    wrap_up();
  end
endmodule : timer16_waveform_control_bench
`default_nettype wire
